// >>> rtl/upper_dma_pkg.sv
// constants for the upper dma controller status, command, request, mask and mode ports
package upper_dma_pkg;
   // ****************************************
   // port addresses
   // ****************************************
   localparam logic [7:0] ADDR_STATUS_CMD = 8'hD0;
   localparam logic [7:0] ADDR_SOFT_REQ = 8'hD2;
   localparam logic [7:0] ADDR_SINGLE_MASK = 8'hD4;
   localparam logic [7:0] ADDR_MODE = 8'hD6;
   localparam logic [7:0] ADDR_MASTER_CLEAR = 8'hDA;
   localparam logic [7:0] ADDR_MASK_CLEAR = 8'hDC;
   localparam logic [7:0] ADDR_MASK_ALL = 8'hDE;
   // ****************************************
   // command bit positions
   // ****************************************
   localparam int CMD_DACK_HIGH = 7;
   localparam int CMD_DREQ_LOW = 6;
   localparam int CMD_ROTATE = 4;
   localparam int CMD_COMPRESSED = 3;
   localparam int CMD_DISABLE = 2;
   localparam int CMD_ADDR_HOLD = 1;
   localparam int CMD_MEM_TO_MEM = 0;
   // ****************************************
   // request, mask and mode port fields
   // ****************************************
   localparam int SEL_LSB = 0;
   localparam int SEL_MSB = 1;
   localparam int ACT_BIT = 2;
   localparam int MODE_LSB = 6;
   localparam int MODE_MSB = 7;
   // ****************************************
   // reset values and timing
   // ****************************************
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [3:0] MASK_RESET = 4'h0;
   localparam logic [2:0] XFER_CYCLES_NORMAL = 3'h4;
   localparam logic [2:0] XFER_CYCLES_COMPRESSED = 3'h3;
   typedef enum logic [1:0] {MODE_DEMAND, MODE_SINGLE, MODE_BLOCK,
      MODE_CASCADE} xfer_mode_e;
endpackage

// >>> rtl/mode_mem_if.sv
// carrier between the controller and its per-channel mode store
interface mode_mem_if;
   logic wr_en;
   logic [1:0] wr_addr;
   logic [7:0] wr_data;
   logic [1:0] rd_addr;
   logic [7:0] rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data,
      output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data,
      input rd_addr, output rd_data);
endinterface

// >>> rtl/mode_mem.sv
// four-entry channel mode store with registered read data
module mode_mem
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_clear,
   mode_mem_if.mem bus
);
   logic [7:0] mem_r [4];
   logic [7:0] mem_nxt [4];
   logic [7:0] rd_r;
   logic [7:0] rd_nxt;

   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (i_clear)
            mem_nxt[i] = 8'h00;
         else if (bus.wr_en && bus.wr_addr == 2'(i))
            mem_nxt[i] = bus.wr_data;
         else
            mem_nxt[i] = mem_r[i];
      end
      rd_nxt = mem_r[bus.rd_addr];
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         for (int i = 0; i < 4; i++)
            mem_r[i] <= 8'h00;
         rd_r <= 8'h00;
      end
      else
      begin
         mem_r <= mem_nxt;
         rd_r <= rd_nxt;
      end
   end

   assign bus.rd_data = rd_r;
endmodule // mode_mem

// >>> rtl/upper_dma_controller.sv
// upper dma controller: status, command, request, mask and mode ports
//
// Summary of operation
// (R1) port D0: read status, write command
// (R2) status 7:4 show unmasked channel requests after polarity correction
// (R3) request bits clear on reset, clear, deassert
// (R4) status 3:0 terminal count, read clears
// (R5) command bit 7 sets acknowledge polarity
// (R6) command bit 6 sets request polarity
// (R7) command bit 4 picks fixed or rotating
// (R8) bit 3 shortens transfer to three cycles
// (R9) bit 2 blocks new dma cycles
// (R10) bit 1 holds channel 0 address
// (R11) bit 0 selects memory to memory
// (R12) software writes zero to bit 5
// (R13) port D2 bit 2 raises soft request
// (R14) soft requests bypass mask, accumulate
// (R15) port D4 changes one selected mask bit
// (R16) bit 2 set masks selected channel
// (R17) port D6 write only mode port
// (R18) mode write: bits 1:0 pick channel
// (R19) port DA write performs master clear
// (R20) port DE reads/writes whole mask
module upper_dma_controller
#(
   parameter int CHANNELS = 4
)
(
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic [7:0] i_addr,
   input wire logic i_io_rd,
   input wire logic i_io_wr,
   input wire logic [7:0] i_data,
   output logic [7:0] o_data,
   input wire logic [3:0] i_dreq,
   output logic [3:0] o_dack,
   input wire logic [3:0] i_tc,
   input wire logic i_xfer_done,
   output logic o_busy,
   output logic [1:0] o_grant_mode,
   output logic [2:0] o_xfer_cycles,
   output logic o_addr_hold,
   output logic o_mem_to_mem
);
   // ****************************************
   // elaboration checks
   // ****************************************
   if (CHANNELS != 4)
   begin : g_bad_channels
      $error("upper dma controller serves exactly four channels");
   end
   if (upper_dma_pkg::SEL_MSB - upper_dma_pkg::SEL_LSB + 1 !=
      $clog2(CHANNELS))
   begin : g_bad_select
      $error("channel select field does not fit the channel count");
   end
   if (upper_dma_pkg::XFER_CYCLES_COMPRESSED >=
      upper_dma_pkg::XFER_CYCLES_NORMAL)
   begin : g_bad_timing
      $error("compressed transfer must be shorter than a normal one");
   end

   // ****************************************
   // reset release
   // ****************************************
   logic [1:0] rst_sync_r;
   logic rst_n;

   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
         rst_sync_r <= 2'b00;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   // only the second flop feeds the design; the first may be metastable
   assign rst_n = rst_sync_r[1];

   // ****************************************
   // port decode
   // ****************************************
   logic wr_cmd;
   logic rd_status;
   logic wr_soft;
   logic wr_single;
   logic wr_mode;
   logic wr_mclr;
   logic wr_mclear_mask;
   logic wr_mask_all;
   logic rd_mask_all;

   assign wr_cmd = i_io_wr && i_addr == upper_dma_pkg::ADDR_STATUS_CMD; // [R1]
   assign rd_status = i_io_rd && i_addr == upper_dma_pkg::ADDR_STATUS_CMD;
   assign wr_soft = i_io_wr && i_addr == upper_dma_pkg::ADDR_SOFT_REQ;
   assign wr_single = i_io_wr && i_addr == upper_dma_pkg::ADDR_SINGLE_MASK;
   assign wr_mode = i_io_wr && i_addr == upper_dma_pkg::ADDR_MODE; // [R17]
   assign wr_mclr = i_io_wr && i_addr == upper_dma_pkg::ADDR_MASTER_CLEAR;
   assign wr_mclear_mask = i_io_wr &&
      i_addr == upper_dma_pkg::ADDR_MASK_CLEAR;
   assign wr_mask_all = i_io_wr && i_addr == upper_dma_pkg::ADDR_MASK_ALL;
   assign rd_mask_all = i_io_rd && i_addr == upper_dma_pkg::ADDR_MASK_ALL;

   // ****************************************
   // register state
   // ****************************************
   logic [7:0] cmd_r, cmd_nxt;
   logic [3:0] mask_r, mask_nxt;
   logic [3:0] soft_r, soft_nxt;
   logic [3:0] req_r, req_nxt;
   logic [3:0] tc_r, tc_nxt;
   logic [7:0] data_r, data_nxt;
   logic [3:0] sensed;
   logic [3:0] sel_dec;

   // a low-active request is inverted before anything looks at it
   assign sensed = cmd_r[upper_dma_pkg::CMD_DREQ_LOW] ? ~i_dreq : i_dreq; // [R6]
   assign sel_dec = 4'h1 << i_data[upper_dma_pkg::SEL_MSB:
      upper_dma_pkg::SEL_LSB];

   always_comb
   begin
      cmd_nxt = cmd_r;
      mask_nxt = mask_r;
      soft_nxt = soft_r;
      data_nxt = 8'h00;
      // reserved bit 5 is stored as written; software keeps it zero
      if (wr_cmd)
         cmd_nxt = i_data; // [R1] [R12]
      if (wr_single)
      begin
         if (i_data[upper_dma_pkg::ACT_BIT])
            mask_nxt = mask_r | sel_dec; // [R15] [R16]
         else
            mask_nxt = mask_r & ~sel_dec; // [R15]
      end
      if (wr_mask_all)
         mask_nxt = i_data[3:0]; // [R20]
      if (wr_mclear_mask)
         mask_nxt = 4'h0;
      // soft request ends at that channel's terminal count
      soft_nxt = soft_r & ~i_tc;
      if (wr_soft && i_data[upper_dma_pkg::ACT_BIT])
         soft_nxt = soft_nxt | sel_dec; // [R13] [R14]
      // status shows the request after polarity correction, unmasked
      req_nxt = sensed; // [R2] [R3]
      // a terminal count in the reading cycle survives the clear
      tc_nxt = (rd_status ? 4'h0 : tc_r) | i_tc; // [R4]
      if (rd_status)
         data_nxt = {req_r, tc_r}; // [R1] [R2] [R4]
      else if (rd_mask_all)
         data_nxt = {4'h0, mask_r}; // [R20]
      if (wr_mclr)
      begin
         cmd_nxt = upper_dma_pkg::CMD_RESET; // [R19]
         mask_nxt = upper_dma_pkg::MASK_RESET;
         soft_nxt = 4'h0;
         req_nxt = 4'h0; // [R3]
         tc_nxt = 4'h0; // [R4] [R19]
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_r <= upper_dma_pkg::CMD_RESET;
         mask_r <= upper_dma_pkg::MASK_RESET; // [R20]
         soft_r <= 4'h0;
         req_r <= 4'h0; // [R3]
         tc_r <= 4'h0; // [R4]
         data_r <= 8'h00;
      end
      else
      begin
         cmd_r <= cmd_nxt;
         mask_r <= mask_nxt;
         soft_r <= soft_nxt;
         req_r <= req_nxt;
         tc_r <= tc_nxt;
         data_r <= data_nxt;
      end
   end
   assign o_data = data_r;

   // ****************************************
   // arbitration and acknowledge
   // ****************************************
   typedef enum logic {ARB_IDLE, ARB_GRANT} arb_state_e;
   arb_state_e state_r, state_nxt;
   logic [1:0] grant_r, grant_nxt;
   logic [1:0] base_r, base_nxt;
   logic [3:0] eligible;
   logic found;
   logic [1:0] pick;
   logic [1:0] idx;
   logic [3:0] ack_act;

   assign eligible = (sensed & ~mask_r) | soft_r; // [R14]

   always_comb
   begin
      found = 1'b0;
      pick = 2'b00;
      idx = 2'b00;
      // search starts at the base; base stays 0 in fixed mode
      for (int i = 0; i < 4; i++)
      begin
         idx = base_r + 2'(i);
         if (!found && eligible[idx])
         begin
            found = 1'b1;
            pick = idx;
         end
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      grant_nxt = grant_r;
      base_nxt = cmd_r[upper_dma_pkg::CMD_ROTATE] ? base_r : 2'b00; // [R7]
      case (state_r)
         ARB_IDLE:
         begin
            // disable only stops new grants; a running one completes
            if (found && !cmd_r[upper_dma_pkg::CMD_DISABLE]) // [R9]
            begin
               state_nxt = ARB_GRANT;
               grant_nxt = pick;
               if (cmd_r[upper_dma_pkg::CMD_ROTATE])
                  base_nxt = pick + 2'b01; // [R7]
            end
         end
         ARB_GRANT:
         begin
            if (i_xfer_done)
               state_nxt = ARB_IDLE;
         end
         default:
            state_nxt = ARB_IDLE;
      endcase
      if (wr_mclr)
      begin
         state_nxt = ARB_IDLE;
         base_nxt = 2'b00;
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ARB_IDLE;
         grant_r <= 2'b00;
         base_r <= 2'b00;
      end
      else
      begin
         state_r <= state_nxt;
         grant_r <= grant_nxt;
         base_r <= base_nxt;
      end
   end

   // one acknowledge per channel; idle pins sit at the inactive level
   for (genvar ch = 0; ch < CHANNELS; ch++)
   begin : g_ack
      assign ack_act[ch] = state_r == ARB_GRANT && grant_r == 2'(ch);
      assign o_dack[ch] = cmd_r[upper_dma_pkg::CMD_DACK_HIGH] ?
         ack_act[ch] : !ack_act[ch]; // [R5]
   end
   assign o_busy = state_r == ARB_GRANT;
   assign o_xfer_cycles = cmd_r[upper_dma_pkg::CMD_COMPRESSED] ?
      upper_dma_pkg::XFER_CYCLES_COMPRESSED :
      upper_dma_pkg::XFER_CYCLES_NORMAL; // [R8]
   assign o_addr_hold = cmd_r[upper_dma_pkg::CMD_ADDR_HOLD]; // [R10]
   assign o_mem_to_mem = cmd_r[upper_dma_pkg::CMD_MEM_TO_MEM]; // [R11]

   // ****************************************
   // channel mode store
   // ****************************************
   mode_mem_if mode_bus ();
   logic [7:0] mode_word;

   assign mode_bus.wr_en = wr_mode;
   assign mode_bus.wr_addr = i_data[upper_dma_pkg::SEL_MSB:
      upper_dma_pkg::SEL_LSB]; // [R18]
   assign mode_bus.wr_data = i_data;
   // read ahead with the grant being taken, so the mode word lines up
   // with the acknowledge instead of trailing it by a cycle
   assign mode_bus.rd_addr = grant_nxt;
   assign mode_word = mode_bus.rd_data;
   assign o_grant_mode = mode_word[upper_dma_pkg::MODE_MSB:
      upper_dma_pkg::MODE_LSB]; // [R18]

   mode_mem u_mode_mem
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(rst_n),
      .i_clear(wr_mclr),
      .bus(mode_bus)
   );
endmodule // upper_dma_controller

// >>> test/upper_dma_chk.sv
// assertions on the upper dma controller ports
module upper_dma_chk
(
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic [7:0] i_addr,
   input wire logic i_io_rd,
   input wire logic i_io_wr,
   input wire logic [7:0] i_data,
   input wire logic [7:0] o_data,
   input wire logic [3:0] i_dreq,
   input wire logic [3:0] o_dack,
   input wire logic [3:0] i_tc,
   input wire logic o_busy,
   input wire logic [2:0] o_xfer_cycles,
   input wire logic o_addr_hold,
   input wire logic o_mem_to_mem
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cmd_r;
   logic st_rd;
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_nrst);
   assign st_rd = i_io_rd && i_addr == 8'hD0;
   // ****
   // command copy; master clear empties it too
   // ****
   always_ff @(posedge i_clk_sys or negedge i_nrst)
      if (!i_nrst)
         cmd_r <= 8'h00;
      else if (i_io_wr && i_addr == 8'hD0)
         cmd_r <= i_data;
      else if (i_io_wr && i_addr == 8'hDA)
         cmd_r <= 8'h00;
   a_xfer_len: assert property (
      o_xfer_cycles == 3'h4 - {2'h0, cmd_r[3]})
      else $error("cycle count differs");
   a_hold_flags: assert property (
      o_addr_hold == cmd_r[1] && o_mem_to_mem == cmd_r[0])
      else $error("engine flags differ");
   a_dack_idle: assert property (
      !o_busy |-> o_dack == {4{!cmd_r[7]}})
      else $error("acknowledge not idle");
   a_disable_stop: assert property (
      cmd_r[2] && !o_busy |=> !o_busy)
      else $error("grant while disabled");
   a_soft_grant: assert property (
      i_io_wr && i_addr == 8'hD2 && i_data[2] && !o_busy && !cmd_r[2]
      ##1 !i_io_wr && !o_busy |=> o_busy)
      else $error("soft request not granted");
   a_undef_read: assert property (
      i_io_rd && i_addr inside {8'hD2, 8'hD4, 8'hD6} |=> o_data == 8'h00)
      else $error("write only port not zero");
   a_tc_clear: assert property (
      st_rd && i_tc == 4'h0 ##1 st_rd && i_tc == 4'h0 |=> o_data[3:0] == 4'h0)
      else $error("count flag kept after read");
   a_raw_req: assert property (
      st_rd && !cmd_r[6] && $stable(i_dreq) && !$past(i_io_wr)
      |=> o_data[7:4] == $past(i_dreq))
      else $error("request flags differ from pins");
   c_rotate: cover property (o_busy && cmd_r[4]);
   c_high: cover property (o_busy && cmd_r[7]);
   c_tc: cover property (st_rd ##1 o_data[3:0] != 4'h0);
endmodule // upper_dma_chk

bind upper_dma_controller upper_dma_chk u_chk (.i_clk_sys, .i_nrst, .i_addr,
   .i_io_rd, .i_io_wr, .i_data, .o_data, .i_dreq, .o_dack, .i_tc, .o_busy,
   .o_xfer_cycles, .o_addr_hold, .o_mem_to_mem);

// >>> test/dma_far_side.sv
// request pins and a transfer engine that ends each grant
module dma_far_side
(
   input wire logic i_clk_sys,
   input wire logic [3:0] i_want,
   input wire logic i_low,
   input wire logic i_high,
   input wire logic [3:0] i_dack,
   input wire logic i_busy,
   input wire logic [2:0] i_len,
   output logic [3:0] o_dreq,
   output logic [3:0] o_tc,
   output logic o_done
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] cnt_r = 3'h0;
   logic [3:0] tc_r = 4'h0;
   logic done_r = 1'b0;
   logic fin;
   assign o_dreq = i_low ? ~i_want : i_want;
   assign o_tc = tc_r;
   assign o_done = done_r;
   // ****
   // a grant lasts the word cycle count, then ends with its count flag
   // ****
   assign fin = i_busy && !done_r && cnt_r + 3'h2 >= i_len;
   always @(posedge i_clk_sys)
   begin
      cnt_r <= i_busy && !done_r ? cnt_r + 3'h1 : 3'h0;
      done_r <= fin;
      tc_r <= fin ? (i_high ? i_dack : ~i_dack) : 4'h0;
   end
endmodule // dma_far_side

// >>> test/upper_dma_controller_tb.sv
// self-checking bench for the upper dma controller
module upper_dma_controller_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_io_rd = 1'b0, i_io_wr = 1'b0;
   logic low = 1'b0, high = 1'b0, i_xfer_done, o_busy, o_addr_hold;
   logic o_mem_to_mem;
   logic [7:0] i_addr = 8'h00, i_data = 8'h00, o_data;
   logic [3:0] want = 4'h0, i_dreq, o_dack, i_tc;
   logic [1:0] o_grant_mode;
   logic [2:0] o_xfer_cycles;
   int n_fail = 0, comparisons = 0;
   always #2.5 i_clk_sys = ~i_clk_sys;
   upper_dma_controller DUT (.i_clk_sys, .i_nrst, .i_addr, .i_io_rd,
      .i_io_wr, .i_data, .o_data, .i_dreq, .o_dack, .i_tc, .i_xfer_done,
      .o_busy, .o_grant_mode, .o_xfer_cycles, .o_addr_hold, .o_mem_to_mem);
   dma_far_side far (.i_clk_sys, .i_want(want), .i_low(low), .i_high(high),
      .i_dack(o_dack), .i_busy(o_busy), .i_len(o_xfer_cycles),
      .o_dreq(i_dreq), .o_tc(i_tc), .o_done(i_xfer_done));
   task end_of_test;
      $display("compares %0d fails %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   // ****
   // one register access; a read compares against d
   // ****
   task acc(input logic r, input logic [7:0] a, input logic [7:0] d);
      i_addr = a;
      i_data = d;
      {i_io_rd, i_io_wr} = {r, !r};
      tick(1);
      {i_io_rd, i_io_wr} = 2'b00;
      if (r)
         chk(o_data, d);
      tick(1);
   endtask
   task grant(input logic [3:0] exp, input logic [1:0] mode);
      for (int i = 0; i < 20 && o_busy !== 1'b1; i++)
         tick(1);
      chk({o_grant_mode, 2'h0, o_dack}, {mode, 2'h0, exp});
      while (o_busy === 1'b1)
         tick(1);
   endtask
   // commands written here keep bit 5 at zero
   task t_ports;
      acc(1, 8'hD0, 8'h00);
      acc(1, 8'hC0, 8'h00);
      acc(0, 8'hD4, 8'h06);
      acc(0, 8'hD4, 8'h05);
      acc(0, 8'hD4, 8'h02);
      acc(1, 8'hDE, 8'h02);
      acc(0, 8'hDE, 8'h0F);
      want = 4'h2;
      acc(1, 8'hD6, 8'h00);
      acc(1, 8'hD2, 8'h00);
      acc(1, 8'hD4, 8'h00);
      acc(1, 8'hD0, 8'h20);
      want = 4'h1;
      low = 1'b1;
      acc(0, 8'hD0, 8'h40);
      acc(1, 8'hD0, 8'h10);
      {want, low} = 5'h00;
      acc(0, 8'hD0, 8'h00);
      $display("ports done");
   endtask
   task t_soft;
      acc(0, 8'hD2, 8'h01);
      tick(2);
      chk({7'h00, o_busy}, 8'h00);
      acc(0, 8'hD2, 8'h05);
      grant(4'hD, 2'h0);
      acc(0, 8'hD2, 8'h04);
      acc(0, 8'hD2, 8'h07);
      grant(4'hE, 2'h0);
      grant(4'h7, 2'h0);
      // back-to-back status reads: the first one clears the count flags
      i_addr = 8'hD0;
      i_io_rd = 1'b1;
      tick(1);
      chk(o_data, 8'h0B);
      tick(1);
      i_io_rd = 1'b0;
      chk(o_data, 8'h00);
      tick(1);
      $display("soft done");
   endtask
   task t_cmd;
      acc(0, 8'hD0, 8'h88);
      chk({o_xfer_cycles, 1'b0, o_dack}, 8'h60);
      high = 1'b1;
      acc(0, 8'hD2, 8'h06);
      grant(4'h4, 2'h0);
      acc(0, 8'hD0, 8'h04);
      high = 1'b0;
      acc(0, 8'hD2, 8'h04);
      tick(2);
      chk({7'h00, o_busy}, 8'h00);
      acc(0, 8'hD0, 8'h03);
      grant(4'hE, 2'h0);
      chk({6'h00, o_addr_hold, o_mem_to_mem}, 8'h03);
      $display("command done");
   endtask
   task t_prio;
      acc(0, 8'hDE, 8'h00);
      acc(0, 8'hD6, 8'hC1);
      acc(0, 8'hD0, 8'h10);
      want = 4'h3;
      grant(4'hE, 2'h0);
      grant(4'hD, 2'h3);
      grant(4'hE, 2'h0);
      want = 4'h0;
      tick(10);
      acc(0, 8'hD0, 8'h00);
      want = 4'h3;
      grant(4'hE, 2'h0);
      grant(4'hE, 2'h0);
      want = 4'h0;
      tick(10);
      $display("priority done");
   endtask
   task t_clear;
      acc(0, 8'hD4, 8'h07);
      acc(0, 8'hD0, 8'h03);
      acc(0, 8'hDA, 8'h5A);
      acc(1, 8'hDE, 8'h00);
      acc(1, 8'hD0, 8'h00);
      chk({6'h00, o_addr_hold, o_mem_to_mem}, 8'h00);
      $display("clear done");
   endtask
   initial
   begin
      tick(20);
      i_nrst = 1'b1;
      tick(3);
      t_ports;
      t_soft;
      t_cmd;
      t_prio;
      t_clear;
      end_of_test;
   end
   // the tests need about 160 cycles
   initial
   begin
      #40000;
      n_fail++;
      end_of_test;
   end
endmodule // upper_dma_controller_tb
